// ### core/sld_ctrl.sv
/*
 * Supply level detector control: enable, range and trim registers,
 * settling timer, valid flag, result bit and interrupt generation.
 * Assumes an external analog comparator whose output is synchronous
 * to i_mclk, and a plain register port with read data one cycle later.
 */
// Chosen here: the address-and-strobe port and the register offsets.
// Summary of operation
// - status bit 0 switches the detector on when 1, off when 0
// - valid flag sets 2 ms after the detector is enabled
// - while valid and enabled, below-threshold raises a maskable request
// - one interrupt per rising edge of the below-threshold bit
// - status bit 2 reads 1 while enabled and supply is below the level, 0 while off
// - status bit 1 is a read-only valid flag
// - control bits 2..0 pick one of eight trim steps
// - control bit 3 picks the coarse range, low 0, high 1
// - request goes to bit 2 of the mid-priority request vector
`default_nettype none
module sld_ctrl
    import sld_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // register port
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // analog comparator
    input wire logic i_cmp_below,
    output logic o_detector_on,
    output logic o_coarse_range_sel,
    output logic [2:0] o_threshold_trim,
    // interrupt
    output logic o_low_supply_irq,
    output logic [7:0] o_mid_priority_irq_reg
);
    sld_bus_req_t req;
    sld_ctrl_t ctrl_q, ctrl_d;
    logic on_q, on_d;
    sld_state_t state_q, state_d;
    logic [SLD_CNT_W-1:0] cnt_q, cnt_d;
    logic below_q, below_d;
    logic ista_q, ista_d;
    logic mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic valid;
    logic rise;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign valid = (state_q == SLD_VALID);

    // =========================================================
    // control and enable registers
    always_comb
    begin
        ctrl_d = ctrl_q;
        on_d = on_q;
        if (req.wr && req.addr == SLD_ADDR_CTRL)
        begin
            ctrl_d.coarse_range_sel = req.wdata[SLD_CTRL_RANGE_BIT];
            ctrl_d.threshold_trim = req.wdata[SLD_TRIM_MSB:0];
        end
        if (req.wr && req.addr == SLD_ADDR_STAT)
            on_d = req.wdata[SLD_STAT_ON_BIT];
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q <= '{coarse_range_sel: 1'b0, threshold_trim: SLD_TRIM_RESET};
            on_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            on_q <= on_d;
        end
    end

    // =========================================================
    // settling timer; a restart only comes from the off state, so
    // rewriting 1 while on does not restart the period
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            SLD_OFF:
            begin
                cnt_d = '0;
                if (on_q)
                    state_d = SLD_SETTLE;
            end
            SLD_SETTLE:
            begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == SLD_CNT_W'(SLD_SETTLE_CYC - 2))
                    state_d = SLD_VALID;
            end
            SLD_VALID:
                cnt_d = cnt_q;
        endcase
        if (!on_q)
        begin
            state_d = SLD_OFF;
            cnt_d = '0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= SLD_OFF;
            cnt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // =========================================================
    // result bit and interrupt; edge detection only while valid so
    // the comparator's settling glitches never raise a request
    sld_edge_det u_edge (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_level(below_q),
        .i_arm(valid & on_q),
        .o_rise(rise)
    );

    always_comb
    begin
        below_d = on_q & i_cmp_below;
        mask_d = mask_q;
        ista_d = ista_q;
        if (req.wr && req.addr == SLD_ADDR_IRQ_MASK)
            mask_d = req.wdata[SLD_IRQ_BIT];
        if (req.rd && req.addr == SLD_ADDR_IRQ_STAT)
            ista_d = 1'b0;
        if (rise)
            ista_d = 1'b1; // set wins over read clear
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            below_q <= 1'b0;
            ista_q <= 1'b0;
            mask_q <= 1'b0;
        end
        else
        begin
            below_q <= below_d;
            ista_q <= ista_d;
            mask_q <= mask_d;
        end
    end

    // maskable level request, routed into the mid-priority vector
    assign o_low_supply_irq = ista_q & mask_q;
    always_comb
    begin
        o_mid_priority_irq_reg = SLD_ZERO_BYTE;
        o_mid_priority_irq_reg[SLD_MID_IRQ_BIT] = o_low_supply_irq;
    end

    // =========================================================
    // read data, one cycle after the strobe; reserved bits are zero
    always_comb
    begin
        rdata_d = SLD_ZERO_BYTE;
        if (req.rd)
        begin
            unique case (req.addr)
                SLD_ADDR_CTRL:
                begin
                    rdata_d[SLD_CTRL_RANGE_BIT] = ctrl_q.coarse_range_sel;
                    rdata_d[SLD_TRIM_MSB:0] = ctrl_q.threshold_trim;
                end
                SLD_ADDR_STAT:
                begin
                    rdata_d[SLD_STAT_ON_BIT] = on_q;
                    rdata_d[SLD_STAT_VALID_BIT] = valid;
                    rdata_d[SLD_STAT_BELOW_BIT] = below_q;
                end
                SLD_ADDR_IRQ_STAT:
                    rdata_d[SLD_IRQ_BIT] = ista_q;
                SLD_ADDR_IRQ_MASK:
                    rdata_d[SLD_IRQ_BIT] = mask_q;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdata_q <= SLD_ZERO_BYTE;
        else
            rdata_q <= rdata_d;
    end

    assign o_rdata = rdata_q;
    assign o_detector_on = on_q;
    assign o_coarse_range_sel = ctrl_q.coarse_range_sel;
    assign o_threshold_trim = ctrl_q.threshold_trim;

    // =========================================================
    // assertions
    // settle age kept apart from the timer's own count, saturating
    localparam logic [SLD_CNT_W-1:0] SLD_AGE_FULL = SLD_CNT_W'(SLD_SETTLE_CYC);
    logic [SLD_CNT_W-1:0] on_age_q, on_age_d;
    always_comb
    begin
        on_age_d = on_age_q;
        if (!on_q)
            on_age_d = '0;
        else if (on_age_q != SLD_AGE_FULL)
            on_age_d = on_age_q + 1'b1;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            on_age_q <= '0;
        else
            on_age_q <= on_age_d;
    end

    sequence s_enable;
        $rose(on_q);
    endsequence
    sequence s_settled;
        on_q && (on_age_q == SLD_AGE_FULL);
    endsequence

    property p_valid_time;
        @(posedge i_mclk) disable iff (!i_rst_n)
        valid |-> on_age_q == SLD_AGE_FULL;
    endproperty
    a_valid_time: assert property (p_valid_time)
        else $error("valid set too early");

    property p_valid_late;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_settled |-> valid;
    endproperty
    a_valid_late: assert property (p_valid_late)
        else $error("valid set too late");

    property p_restart;
        @(posedge i_mclk) disable iff (!i_rst_n)
        s_enable |-> !valid ##1 !valid;
    endproperty
    a_restart: assert property (p_restart)
        else $error("valid kept across a restart");

    property p_off_clears;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !on_q |-> ##1 !valid;
    endproperty
    a_off_clears: assert property (p_off_clears)
        else $error("valid stayed after disable");

    property p_rise_sets;
        @(posedge i_mclk) disable iff (!i_rst_n)
        rise |=> ista_q;
    endproperty
    a_rise_sets: assert property (p_rise_sets)
        else $error("rise did not set status");

    property p_irq_mask;
        @(posedge i_mclk) disable iff (!i_rst_n)
        !mask_q |-> !o_low_supply_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("masked interrupt seen");

    property p_route;
        @(posedge i_mclk) disable iff (!i_rst_n)
        o_mid_priority_irq_reg[SLD_MID_IRQ_BIT] == o_low_supply_irq;
    endproperty
    a_route: assert property (p_route)
        else $error("interrupt not routed");

    property p_stat_read;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (req.rd && req.addr == SLD_ADDR_STAT) |=>
            o_rdata[SLD_STAT_VALID_BIT] == $past(valid)
            && o_rdata[7:3] == 5'h00;
    endproperty
    a_stat_read: assert property (p_stat_read)
        else $error("status readback wrong");

    property p_below_read;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (req.rd && req.addr == SLD_ADDR_STAT) |=>
            o_rdata[SLD_STAT_BELOW_BIT] == $past(below_q);
    endproperty
    a_below_read: assert property (p_below_read)
        else $error("result readback wrong");

    property p_on_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (req.wr && req.addr == SLD_ADDR_STAT) |=>
            o_detector_on == $past(req.wdata[SLD_STAT_ON_BIT]);
    endproperty
    a_on_write: assert property (p_on_write)
        else $error("enable write lost");

    property p_trim_write;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (req.wr && req.addr == SLD_ADDR_CTRL) |=>
            o_threshold_trim == $past(req.wdata[SLD_TRIM_MSB:0])
            && o_coarse_range_sel == $past(req.wdata[SLD_CTRL_RANGE_BIT]);
    endproperty
    a_trim_write: assert property (p_trim_write)
        else $error("control write lost");

    property p_start;
        @(posedge i_mclk) disable iff (!i_rst_n)
        (state_q == SLD_OFF && on_q) |=> state_q == SLD_SETTLE;
    endproperty
    a_start: assert property (p_start)
        else $error("measurement did not start");
endmodule
`default_nettype wire

// ### core/sld_pkg.sv
/*
 * Shared constants and types for the supply level detector control block:
 * register indices, field positions, reset values and settling time.
 * Assumes a single 100 MHz system clock and a plain register port.
 */
`default_nettype none
package sld_pkg;
    // =========================================================
    // register map (indices on the plain register port)
    localparam logic [1:0] SLD_ADDR_CTRL = 2'h0;
    localparam logic [1:0] SLD_ADDR_STAT = 2'h1;
    localparam logic [1:0] SLD_ADDR_IRQ_STAT = 2'h2;
    localparam logic [1:0] SLD_ADDR_IRQ_MASK = 2'h3;
    // =========================================================
    // field positions
    localparam int SLD_STAT_ON_BIT = 0;
    localparam int SLD_STAT_VALID_BIT = 1;
    localparam int SLD_STAT_BELOW_BIT = 2;
    localparam int SLD_CTRL_RANGE_BIT = 3;
    localparam int SLD_MID_IRQ_BIT = 2;
    localparam int SLD_TRIM_MSB = 2;
    localparam int SLD_IRQ_BIT = 0;
    localparam logic [7:0] SLD_ZERO_BYTE = 8'h00;
    localparam logic [2:0] SLD_TRIM_RESET = 3'h0;
    localparam logic [2:0] SLD_TRIM_NOMINAL = 3'h3;
    // =========================================================
    // settling time
    localparam int SLD_CLK_MHZ = 100;
    localparam int SLD_SETTLE_US = 2000;
    localparam int SLD_SETTLE_CYC = SLD_SETTLE_US * SLD_CLK_MHZ;
    localparam int SLD_CNT_W = 18;
    // =========================================================
    // types
    typedef enum logic [1:0] {SLD_OFF, SLD_SETTLE, SLD_VALID} sld_state_t;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sld_bus_req_t;
    typedef struct packed {
        logic coarse_range_sel;
        logic [2:0] threshold_trim;
    } sld_ctrl_t;
endpackage
`default_nettype wire

// ### core/sld_edge_det.sv
/*
 * Rising edge detector with one register stage.
 * Assumes the input is synchronous to the clock.
 */
`default_nettype none
module sld_edge_det
    import sld_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // level in, pulse out
    input wire logic i_level,
    input wire logic i_arm,
    output logic o_rise
);
    logic prev_q;
    logic prev_d;

    // =========================================================
    // previous value; cleared while disarmed so a level already high
    // when arming counts as a rising edge
    always_comb
    begin
        prev_d = i_arm & i_level;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            prev_q <= 1'b0;
        else
            prev_q <= prev_d;
    end

    assign o_rise = i_arm & i_level & ~prev_q;
endmodule
`default_nettype wire

// ### sim/sld_cmp_model.sv
/*
 * Behavioural model of the analog supply comparator beside the block.
 * Assumes the bench gives the supply level in millivolts, and that the
 * comparator output is sampled by the block on i_mclk.
 */
`default_nettype none
module sld_cmp_model
    import sld_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // settings from the block
    input wire logic i_on,
    input wire logic i_range,
    input wire logic [2:0] i_trim,
    // supply level in millivolts
    input wire logic [11:0] i_supply_mv,
    // result
    output logic o_below
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================
    // threshold table, index {range, trim}, in millivolts
    logic [11:0] lvl [16] = '{12'd1530, 12'd1440, 12'd1360, 12'd1290,
        12'd1220, 12'd1160, 12'd1110, 12'd1060, 12'd3060, 12'd2880,
        12'd2720, 12'd2570, 12'd2440, 12'd2330, 12'd2220, 12'd2130};

    initial o_below = 1'b0;

    // switched off, the output means nothing: toggle so no one trusts it
    always @(posedge i_mclk)
        o_below <= i_on ? (i_supply_mv < lvl[{i_range, i_trim}])
                        : ~o_below;
endmodule
`default_nettype wire

// ### sim/supply_level_detector_ctrl_tb_top.sv
/*
 * Self-checking bench for the supply level detector control block.
 * Assumes the comparator model beside it; one full settling period
 * is waited out, since the count is a package constant.
 */
`default_nettype none
module supply_level_detector_ctrl_tb_top
    import sld_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst_n, wr, rd, cmp_below, det_on, range, irq;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, mid, d;
    logic [2:0] trim;
    logic [11:0] supply_mv;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;

    // ======================================================
    // design and comparator model
    sld_ctrl uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_cmp_below(cmp_below), .o_detector_on(det_on),
        .o_coarse_range_sel(range), .o_threshold_trim(trim),
        .o_low_supply_irq(irq), .o_mid_priority_irq_reg(mid));
    sld_cmp_model cmp (.i_mclk(mclk), .i_on(det_on), .i_range(range),
        .i_trim(trim), .i_supply_mv(supply_mv), .o_below(cmp_below));

    always #5 mclk = ~mclk;

    // ======================================================
    // tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk({7'h00, irq}, 8'h01);
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one settling period plus margin; a hang ends here
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 260000)
        begin
            fail_count++;
            give_verdict();
        end
    end

    // ======================================================
    // main sequence
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        supply_mv = 12'd1400;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        for (int a = 0; a < 4; a++)
        begin
            rd_reg(2'(a), d);
            chk(d, SLD_ZERO_BYTE);
        end
        chk(mid, 8'h00);
        // every range and trim code, reserved bits written high
        for (int i = 0; i < 16; i++)
        begin
            wr_reg(SLD_ADDR_CTRL, 8'hF0 | 8'(i));
            rd_reg(SLD_ADDR_CTRL, d);
            chk(d, 8'(i));
            chk({4'h0, range, trim}, 8'(i));
        end
        wr_reg(SLD_ADDR_STAT, 8'h06);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h00);
        wr_reg(SLD_ADDR_CTRL, 8'h03);
        wr_reg(SLD_ADDR_IRQ_MASK, 8'h01);
        wr_reg(SLD_ADDR_IRQ_STAT, 8'h01);
        wr_reg(SLD_ADDR_STAT, 8'h01);
        chk({7'h00, det_on}, 8'h01);
        // the comparator output is stale for a cycle after switch-on
        repeat (2) @(posedge mclk);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h01);
        repeat (199890) @(posedge mclk);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h01);
        repeat (200) @(posedge mclk);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h03);
        // supply drops below 1.29 V
        supply_mv <= 12'd1200;
        wait_irq();
        chk(mid, 8'h04);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h07);
        rd_reg(SLD_ADDR_IRQ_STAT, d);
        chk(d, 8'h01);
        repeat (2) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        rd_reg(SLD_ADDR_IRQ_STAT, d);
        chk(d, 8'h00);
        // masked event stays latched until unmasked
        supply_mv <= 12'd1400;
        wr_reg(SLD_ADDR_IRQ_MASK, 8'h00);
        repeat (4) @(posedge mclk);
        supply_mv <= 12'd1200;
        repeat (4) @(posedge mclk);
        chk({7'h00, irq}, 8'h00);
        wr_reg(SLD_ADDR_IRQ_MASK, 8'h01);
        wait_irq();
        rd_reg(SLD_ADDR_IRQ_STAT, d);
        chk(d, 8'h01);
        // high range: 2.13 V then 3.06 V
        wr_reg(SLD_ADDR_CTRL, 8'h0F);
        supply_mv <= 12'd2200;
        repeat (4) @(posedge mclk);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h03);
        wr_reg(SLD_ADDR_CTRL, 8'h08);
        wait_irq();
        rd_reg(SLD_ADDR_IRQ_STAT, d);
        // disable while the comparator output wanders
        wr_reg(SLD_ADDR_STAT, 8'h00);
        chk({7'h00, det_on}, 8'h00);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h00);
        repeat (50) @(posedge mclk);
        rd_reg(SLD_ADDR_IRQ_STAT, d);
        chk(d, 8'h00);
        chk({7'h00, irq}, 8'h00);
        wr_reg(SLD_ADDR_STAT, 8'h01);
        repeat (100) @(posedge mclk);
        rd_reg(SLD_ADDR_STAT, d);
        chk(d, 8'h05);
        give_verdict();
    end
endmodule
`default_nettype wire
